/* File: design/ccx_defines.svh */
// Offsets, field positions, opcodes, reset values and timing counts of the executor
`ifndef CCX_DEFINES_SVH
`define CCX_DEFINES_SVH
// ==========================================================================
// Register byte offsets
`define CCX_INSTR_OFS       12'h000
`define CCX_WORK_OFS        12'h004
`define CCX_STATUS_OFS      12'h008
`define CCX_WDOG_OFS        12'h00C
`define CCX_FILE_TAG        3'h1
// ==========================================================================
// Status field positions and reset values
`define CCX_ZERO_BIT        2
`define CCX_POWERDOWN_BIT   3
`define CCX_TIMEOUT_BIT     4
`define CCX_TIMEOUT_RST     1'b1
`define CCX_POWERDOWN_RST   1'b1
`define CCX_WORK_RST        8'h00
// ==========================================================================
// Opcode fields
`define CCX_CLEAR_PFX       7'h02
`define CCX_RESTART_CODE    14'h0064
`define CCX_DEC_PFX         6'h03
`define CCX_COMP_PFX        6'h09
// ==========================================================================
// Timing
`define CCX_EXEC_CYCLES     1
`endif

/* File: design/ccx_pkg.sv */
// Types shared by the clear, decrement and complement executor
package ccx_pkg;
  // ========================================================================
  // Decoded operation, one-hot
  typedef enum logic [4:0] {
    ccx_op_none  = 5'h01,
    ccx_op_clear = 5'h02,
    ccx_op_wdog  = 5'h04,
    ccx_op_dec   = 5'h08,
    ccx_op_comp  = 5'h10
  } ccx_op_t;
endpackage

/* File: design/ccx_exec_if.sv */
// Operand and result bundle between the core and its execute unit
`timescale 1ns/100ps
interface ccx_exec_if #(parameter int DATA_W = 8);
  logic [13:0]         instr;
  logic [DATA_W-1:0]   file_val;
  ccx_pkg::ccx_op_t    op;
  logic [DATA_W-1:0]   result;
  logic                to_work;
  logic                to_file;
  logic                z_write;
  logic                z_val;
  logic                wdog_clear;
  modport core (output instr, file_val,
                input  op, result, to_work, to_file, z_write, z_val, wdog_clear);
  modport alu  (input  instr, file_val,
                output op, result, to_work, to_file, z_write, z_val, wdog_clear);
endinterface

/* File: design/ccx_alu.sv */
// Execute unit: decodes one instruction word and forms its result
`timescale 1ns/100ps
`include "ccx_defines.svh"
module ccx_alu (
  // Operands in, results out
  ccx_exec_if.alu ex
);
  // ========================================================================
  // Decode
  function automatic ccx_pkg::ccx_op_t ccx_decode(input logic [13:0] iw);
    ccx_pkg::ccx_op_t op;
    op = ccx_pkg::ccx_op_none;
    if (iw == `CCX_RESTART_CODE) begin
      op = ccx_pkg::ccx_op_wdog;
    end else if (iw[13:7] == `CCX_CLEAR_PFX) begin
      op = ccx_pkg::ccx_op_clear;
    end else if (iw[13:8] == `CCX_DEC_PFX) begin
      op = ccx_pkg::ccx_op_dec;
    end else if (iw[13:8] == `CCX_COMP_PFX) begin
      op = ccx_pkg::ccx_op_comp;
    end
    return op;
  endfunction

  // ========================================================================
  // Execute
  always_comb begin
    ex.op         = ccx_decode(ex.instr);
    ex.result     = '0;
    ex.to_work    = 1'b0;
    ex.to_file    = 1'b0;
    ex.z_write    = 1'b0;
    ex.z_val      = 1'b0;
    ex.wdog_clear = 1'b0;
    case (ex.op)
      ccx_pkg::ccx_op_clear: begin
        ex.to_work = 1'b1;
        ex.z_write = 1'b1;
        ex.z_val   = 1'b1;
      end
      ccx_pkg::ccx_op_wdog: begin
        ex.wdog_clear = 1'b1;
      end
      ccx_pkg::ccx_op_dec: begin
        ex.result  = ex.file_val + '1;
        ex.to_work = ~ex.instr[7];
        ex.to_file = ex.instr[7];
        ex.z_write = 1'b1;
        ex.z_val   = (ex.result == '0);
      end
      ccx_pkg::ccx_op_comp: begin
        ex.result  = ~ex.file_val;
        ex.to_work = ~ex.instr[7];
        ex.to_file = ex.instr[7];
        ex.z_write = 1'b1;
        ex.z_val   = (ex.result == '0);
      end
      default: begin
        ex.result = '0;
      end
    endcase
  end
endmodule

/* File: design/ccx_core.sv */
// Executor core: AHB-Lite registers, file registers, work register, watchdog
//
// The AHB-Lite register port and the address map were left to the implementer.
`timescale 1ns/100ps
`include "ccx_defines.svh"
module ccx_core #(
  parameter int FILE_DEPTH = 128,
  parameter int DATA_W     = 8
) (
  // Clock and reset
  input  wire logic              hclk,
  input  wire logic              hresetn,
  // AHB-Lite slave
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic [31:0]            hrdata,
  // Status
  output logic                   zero_flag,
  output logic                   timeout_status_bit,
  output logic                   powerdown_status_bit,
  output logic [7:0]             watchdog_counter
);
  localparam int IDX_W = $clog2(FILE_DEPTH);

  typedef struct packed {
    logic [FILE_DEPTH-1:0][DATA_W-1:0] file;
    logic [DATA_W-1:0]                 work;
    logic                              zero;
    logic                              timeout;
    logic                              powerdown;
    logic [7:0]                        wdog;
    logic [7:0]                        presc;
    logic                              dph_wr;
    logic [11:0]                       dph_addr;
    logic [31:0]                       rdata;
    logic                              ready;
    logic [13:0]                       last_instr;
  } ccx_core_state_t;

  ccx_core_state_t s_reg;
  ccx_core_state_t s_next;
  ccx_exec_if #(.DATA_W(DATA_W)) ex ();
  logic            exec_now;
  logic [IDX_W-1:0] dph_idx;
  logic            dph_file;

  // ========================================================================
  // Execute unit
  ccx_alu u_alu (
    .ex (ex)
  );

  assign exec_now    = s_reg.dph_wr && (s_reg.dph_addr == `CCX_INSTR_OFS);
  assign dph_idx     = s_reg.dph_addr[IDX_W+1:2];
  assign dph_file    = (s_reg.dph_addr[11:9] == `CCX_FILE_TAG);
  assign ex.instr    = exec_now ? hwdata[13:0] : 14'h0000;
  assign ex.file_val = s_reg.file[ex.instr[IDX_W-1:0]];

  // ========================================================================
  // Next state
  always_comb begin
    logic       carry;
    logic [7:0] presc_inc;
    carry         = 1'b0;
    presc_inc     = 8'h00;
    s_next        = s_reg;
    s_next.ready  = 1'b1;
    s_next.dph_wr = 1'b0;
    {carry, presc_inc} = {1'b0, s_reg.presc} + 9'h001;
    s_next.presc = presc_inc;
    if (carry) begin
      s_next.wdog = s_reg.wdog + 8'h01;
      if (s_reg.wdog == 8'hFF) begin
        s_next.timeout = 1'b0;
      end
    end
    if (s_reg.dph_wr) begin
      if (exec_now) begin
        s_next.last_instr = hwdata[13:0];
        if (ex.to_work) begin
          s_next.work = ex.result;
        end
        if (ex.to_file) begin
          s_next.file[ex.instr[IDX_W-1:0]] = ex.result;
        end
        if (ex.z_write) begin
          s_next.zero = ex.z_val;
        end
        if (ex.wdog_clear) begin
          s_next.wdog      = 8'h00;
          s_next.presc     = 8'h00;
          s_next.timeout   = 1'b1;
          s_next.powerdown = 1'b1;
        end
      end else if (s_reg.dph_addr == `CCX_WORK_OFS) begin
        s_next.work = hwdata[DATA_W-1:0];
      end else if (s_reg.dph_addr == `CCX_STATUS_OFS) begin
        s_next.zero = hwdata[`CCX_ZERO_BIT];
      end else if (dph_file) begin
        s_next.file[dph_idx] = hwdata[DATA_W-1:0];
      end
    end
    if (hsel && hready && htrans[1]) begin
      s_next.dph_wr   = hwrite;
      s_next.dph_addr = {haddr[11:2], 2'b00};
      s_next.rdata    = 32'h0000_0000;
      if (!hwrite) begin
        if (haddr[11:9] == `CCX_FILE_TAG) begin
          s_next.rdata[DATA_W-1:0] = s_next.file[haddr[IDX_W+1:2]];
        end else begin
          case ({haddr[11:2], 2'b00})
            `CCX_INSTR_OFS:  s_next.rdata[13:0] = s_next.last_instr;
            `CCX_WORK_OFS:   s_next.rdata[DATA_W-1:0] = s_next.work;
            `CCX_STATUS_OFS: begin
              s_next.rdata[`CCX_ZERO_BIT]      = s_next.zero;
              s_next.rdata[`CCX_POWERDOWN_BIT] = s_next.powerdown;
              s_next.rdata[`CCX_TIMEOUT_BIT]   = s_next.timeout;
            end
            `CCX_WDOG_OFS:   s_next.rdata[15:0] = {s_next.presc, s_next.wdog};
            default:         s_next.rdata = 32'h0000_0000;
          endcase
        end
      end
    end
  end

  // ========================================================================
  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_reg           <= '0;
      s_reg.work      <= `CCX_WORK_RST;
      s_reg.timeout   <= `CCX_TIMEOUT_RST;
      s_reg.powerdown <= `CCX_POWERDOWN_RST;
      s_reg.ready     <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign hreadyout            = s_reg.ready;
  assign hresp                = 1'b0;
  assign hrdata               = s_reg.rdata;
  assign zero_flag            = s_reg.zero;
  assign timeout_status_bit   = s_reg.timeout;
  assign powerdown_status_bit = s_reg.powerdown;
  assign watchdog_counter     = s_reg.wdog;

  // ========================================================================
  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_restart;
    exec_now && ex.op == ccx_pkg::ccx_op_wdog;
  endsequence
  sequence s_dec(d);
    exec_now && ex.op == ccx_pkg::ccx_op_dec && ex.instr[7] == d;
  endsequence
  sequence s_comp;
    exec_now && ex.op == ccx_pkg::ccx_op_comp;
  endsequence

  a_clear_work: assert property (
    exec_now && hwdata[13:7] == `CCX_CLEAR_PFX |=> s_reg.work == '0 && zero_flag)
    else $error("work clear did not zero work and set zero");
  a_restart_counter: assert property (
    s_restart |=> watchdog_counter == 8'h00 ##1 watchdog_counter == 8'h00)
    else $error("watchdog counter not restarted");
  a_restart_prescaler: assert property (
    s_restart |=> s_reg.presc == 8'h00 ##1 s_reg.presc == 8'h01)
    else $error("prescaler not restarted");
  a_restart_status: assert property (
    s_restart |=> timeout_status_bit && powerdown_status_bit && $stable(zero_flag))
    else $error("restart status bits wrong");
  a_dec_to_work: assert property (
    s_dec(1'b0) |=> s_reg.work == $past(ex.file_val) - 1'b1
      && zero_flag == (s_reg.work == '0))
    else $error("decrement to work wrong");
  a_dec_to_file: assert property (
    s_dec(1'b1) |=> s_reg.file[$past(ex.instr[IDX_W-1:0])] == $past(ex.file_val) - 1'b1
      && $stable(s_reg.work))
    else $error("decrement to file wrong");
  a_comp_result: assert property (
    s_comp |=> (($past(ex.instr[7]) ? s_reg.file[$past(ex.instr[IDX_W-1:0])] : s_reg.work)
      == ~$past(ex.file_val)) && zero_flag == ($past(ex.file_val) == '1))
    else $error("complement result wrong");
  a_single_cycle: assert property (
    exec_now |-> hreadyout ##1 hreadyout[*2])
    else $error("instruction stalled the bus");
  a_dec_file_zero: assert property (
    s_dec(1'b1) |=> zero_flag == (s_reg.file[$past(ex.instr[IDX_W-1:0])] == '0))
    else $error("decrement to file zero flag wrong");
  a_dec_keeps_file: assert property (
    s_dec(1'b0) |=> s_reg.file[$past(ex.instr[IDX_W-1:0])] == $past(ex.file_val))
    else $error("decrement to work changed file");
  a_comp_keeps_work: assert property (
    s_comp ##0 ex.instr[7] |=> $stable(s_reg.work))
    else $error("complement to file changed work");
  a_restart_keeps_work: assert property (
    s_restart |=> $stable(s_reg.work))
    else $error("restart changed work");
  a_other_keeps_wdog: assert property (
    exec_now && ex.op != ccx_pkg::ccx_op_wdog && s_reg.presc != 8'hFF
      |=> watchdog_counter == $past(watchdog_counter))
    else $error("watchdog counter moved without restart");
  a_exec_recorded: assert property (
    exec_now |=> s_reg.last_instr == $past(hwdata[13:0]))
    else $error("executed word not recorded in one cycle");
endmodule

/* File: tb/ccx_tb.sv */
// Self-checking testbench for the clear, decrement and complement executor
`timescale 1ns/100ps
`include "ccx_defines.svh"
module testbench;
  // ==========================================================================
  // Signals
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hready;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        zero_flag;
  logic        timeout_status_bit;
  logic        powerdown_status_bit;
  logic [7:0]  watchdog_counter;
  logic [31:0] rd;
  int          err_total;
  int          checked;
  localparam logic [31:0] A_INSTR = {20'h000, `CCX_INSTR_OFS};
  localparam logic [31:0] A_WORK  = {20'h000, `CCX_WORK_OFS};
  localparam logic [31:0] A_STAT  = {20'h000, `CCX_STATUS_OFS};
  localparam logic [31:0] A_WDOG  = {20'h000, `CCX_WDOG_OFS};
  assign hready = hreadyout;
  // ==========================================================================
  // Design
  ccx_core u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .zero_flag(zero_flag),
    .timeout_status_bit(timeout_status_bit), .powerdown_status_bit(powerdown_status_bit),
    .watchdog_counter(watchdog_counter)
  );
  // ==========================================================================
  // Bus and compare helpers
  function automatic logic [31:0] fa(input int f);
    return 32'h0000_0200 + 32'(f * 4);
  endfunction
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask
  task automatic rdchk(input string n, input logic [31:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(n, e, rd);
  endtask
  task automatic ex(input logic [13:0] w);
    bus(1'b1, A_INSTR, {18'h0, w});
    #1;
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_reset;
    chk("reset zero", 32'h0, {31'h0, zero_flag});
    chk("reset timeout", 32'h1, {31'h0, timeout_status_bit});
    chk("reset powerdown", 32'h1, {31'h0, powerdown_status_bit});
    rdchk("reset work", A_WORK, 32'h0);
  endtask
  task automatic t_clear;
    bus(1'b1, A_WORK, 32'h0000_005A);
    bus(1'b1, A_STAT, 32'h0);
    ex({`CCX_CLEAR_PFX, 7'h55});
    chk("clear zero", 32'h1, {31'h0, zero_flag});
    rdchk("clear work", A_WORK, 32'h0);
  endtask
  task automatic t_dec;
    bus(1'b1, A_WORK, 32'h0000_0033);
    bus(1'b1, fa(127), 32'h0000_0001);
    ex({`CCX_DEC_PFX, 1'b1, 7'h7F});
    chk("dec1 zero", 32'h1, {31'h0, zero_flag});
    rdchk("dec1 file", fa(127), 32'h0);
    rdchk("dec1 work", A_WORK, 32'h0000_0033);
    ex({`CCX_DEC_PFX, 1'b0, 7'h7F});
    chk("dec0 zero", 32'h0, {31'h0, zero_flag});
    rdchk("dec0 work", A_WORK, 32'h0000_00FF);
    rdchk("dec0 file", fa(127), 32'h0);
  endtask
  task automatic t_comp;
    bus(1'b1, fa(3), 32'h0000_0013);
    bus(1'b1, fa(4), 32'h0000_00FF);
    ex({`CCX_COMP_PFX, 1'b0, 7'h03});
    chk("comp0 zero", 32'h0, {31'h0, zero_flag});
    rdchk("comp0 work", A_WORK, 32'h0000_00EC);
    rdchk("comp0 file", fa(3), 32'h0000_0013);
    ex({`CCX_COMP_PFX, 1'b1, 7'h04});
    chk("comp1 zero", 32'h1, {31'h0, zero_flag});
    rdchk("comp1 file", fa(4), 32'h0);
    rdchk("comp1 work", A_WORK, 32'h0000_00EC);
  endtask
  task automatic t_other;
    bus(1'b1, A_WORK, 32'h0000_005A);
    bus(1'b1, A_STAT, 32'h0);
    ex({7'h03, 7'h11});
    chk("bit7 set zero", 32'h0, {31'h0, zero_flag});
    chk("bit7 set ready", 32'h1, {31'h0, hreadyout});
    rdchk("bit7 set work", A_WORK, 32'h0000_005A);
    ex(14'h3FFF);
    rdchk("last word", A_INSTR, 32'h0000_3FFF);
    rdchk("unknown work", A_WORK, 32'h0000_005A);
  endtask
  task automatic t_wdog;
    int n;
    for (n = 0; n < 70000 && timeout_status_bit !== 1'b0; n++) @(posedge hclk);
    chk("wdog expired", 32'h0, {31'h0, timeout_status_bit});
    for (n = 0; n < 300 && watchdog_counter === 8'h00; n++) @(posedge hclk);
    chk("wdog running", 32'h1, {24'h0, watchdog_counter});
    bus(1'b1, A_STAT, 32'h1 << `CCX_ZERO_BIT);
    ex(`CCX_RESTART_CODE);
    chk("restart counter", 32'h0, {24'h0, watchdog_counter});
    chk("restart timeout", 32'h1, {31'h0, timeout_status_bit});
    chk("restart powerdown", 32'h1, {31'h0, powerdown_status_bit});
    chk("restart zero", 32'h1, {31'h0, zero_flag});
    bus(1'b0, A_WDOG, 32'h0);
    chk("restart wdog cnt", 32'h0, {24'h0, rd[7:0]});
    checked++;
    if (rd[15:8] > 8'h04 || $isunknown(rd[15:8])) begin
      err_total++;
      $display("Error restart prescaler expected below %h seen %h", 8'h05, rd[15:8]);
    end
  endtask
  // ==========================================================================
  // Verdict
  task automatic report_and_stop;
    if (err_total == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ==========================================================================
  // Clock, reset, sequence and watchdog
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  initial begin
    hresetn   = 1'b0;
    hsel      = 1'b1;
    haddr     = 32'h0;
    htrans    = 2'b00;
    hwrite    = 1'b0;
    hsize     = 3'h2;
    hwdata    = 32'h0;
    err_total = 0;
    checked   = 0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_clear();
    t_dec();
    t_comp();
    t_other();
    t_wdog();
    report_and_stop();
  end
  initial begin
    #1000000;
    err_total++;
    report_and_stop();
  end
endmodule
